// [tcc_pkg.sv]
// constants shared by the timer capture/compare control block
`default_nettype none
package tcc_pkg;
   // bus geometry
   localparam int ADDR_W = 9;
   localparam int IDX_W = 7;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int TIMERS = 4;
   localparam int CAP_CH = 4;
   // register indices, byte address is four times the index
   localparam logic [6:0] IER_IDX [0:3] = '{7'h61, 7'h66, 7'h70, 7'h75};
   localparam logic [6:0] RELOAD_IDX [0:3] = '{7'h64, 7'h69, 7'h73, 7'h78};
   localparam logic [6:0] CAP1_IDX = 7'h6A;
   localparam logic [6:0] CAP3_IDX = 7'h7B;
   // interrupt enable fields
   localparam int IER_USED_W = 7;
   localparam int CMP_EN_LSB = 3;
   localparam int CMP_EN_MSB = 6;
   localparam int CMP_TIMER = 3;
   // capture edge control fields
   localparam int CAP_A_LSB = 0;
   localparam int CAP_B_LSB = 2;
   localparam int CAP_USED_W = 4;
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // reset values and bus responses
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [tcc_edge_detect.sv]
// capture edge detector for one capture input
`default_nettype none
module tcc_edge_detect (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic capture_in,
   input wire logic [1:0] edge_sel,
   output logic capture_pulse
);
   logic prev_level;
   logic armed;
   wire logic rise_seen;
   wire logic fall_seen;
   wire logic next_pulse;

   // edge decode; codes 01 fall, 10 rise, 11 both, 00 off
   assign rise_seen = armed && !prev_level && capture_in;
   assign fall_seen = armed && prev_level && !capture_in;
   assign next_pulse = (edge_sel[0] && fall_seen) || (edge_sel[1] && rise_seen);

   // previous level, armed one cycle after reset so no false edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_level <= 1'b0;
         armed <= 1'b0;
         capture_pulse <= 1'b0;
      end else begin
         prev_level <= capture_in;
         armed <= 1'b1;
         capture_pulse <= next_pulse;
      end
   end

   fall_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (edge_sel == tcc_pkg::EDGE_FALL) |-> ##1 (capture_pulse == $past(fall_seen)))
      else $error("falling edge capture wrong");
   rise_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (edge_sel == tcc_pkg::EDGE_RISE) |-> ##1 (capture_pulse == $past(rise_seen)))
      else $error("rising edge capture wrong");
   off_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (edge_sel == tcc_pkg::EDGE_OFF) |=> !capture_pulse)
      else $error("capture while disabled");
endmodule // tcc_edge_detect
`default_nettype wire

// [tcc_axil_slave.sv]
// axi4-lite slave front end for the byte-wide timer registers
`default_nettype none
module tcc_axil_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [8:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [8:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [6:0] wr_index,
   output logic [7:0] wr_data,
   output logic wr_lane0,
   input wire logic wr_hit,
   output logic [6:0] rd_index,
   input wire logic [7:0] rd_data,
   input wire logic rd_hit
);
   logic aw_full;
   logic w_full;
   logic [6:0] aw_index;
   logic [7:0] w_byte;
   logic w_lane0;
   wire logic aw_take;
   wire logic w_take;
   wire logic ar_take;

   // handshakes and write commit
   assign aw_take = awvalid && awready;
   assign w_take = wvalid && wready;
   assign ar_take = arvalid && arready;
   assign wr_en = aw_full && w_full && !bvalid;
   assign wr_index = aw_index;
   assign wr_data = w_byte;
   assign wr_lane0 = w_lane0;
   assign rd_index = araddr[8:2];

   // write channels, address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_index <= 7'h00;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= tcc_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            awready <= 1'b0;
            aw_full <= 1'b1;
            aw_index <= awaddr[8:2];
         end
         if (w_take) begin
            wready <= 1'b0;
            w_full <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane0 <= wstrb[0];
         end
         if (wr_en) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // read channel, data registered at address acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= tcc_pkg::RESP_OKAY;
      end else if (ar_take) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_data};
         rresp <= rd_hit ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule // tcc_axil_slave
`default_nettype wire

// [tcc_top.sv]
// timer capture/compare control registers with axi4-lite access
// Contract
// - timer 3 enable bits 6..3 gate compare events 3..0 into requests, compare mode only
// - reload value is high byte above low byte, high bit 7 is bit 15
// - reload high byte is write-only, any value, zero after reset
// - edge field b: 00 off, 01 falling, 10 rising, 11 both edges
// - timer 1 fields b/a serve inputs 1/0, timer 3 fields b/a inputs 3/2
// - capture control registers exist only on timers 1 and 3
// - enable bits of functions absent in a timer have no effect
`default_nettype none
module tcc_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [8:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [8:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] reload_low_byte_0,
   input wire logic [7:0] reload_low_byte_1,
   input wire logic [7:0] reload_low_byte_2,
   input wire logic [7:0] reload_low_byte_3,
   output logic [15:0] reload_value_0,
   output logic [15:0] reload_value_1,
   output logic [15:0] reload_value_2,
   output logic [15:0] reload_value_3,
   input wire logic output_compare_mode,
   input wire logic compare_channel_0,
   input wire logic compare_channel_1,
   input wire logic compare_channel_2,
   input wire logic compare_channel_3,
   output logic compare0_irq,
   output logic compare1_irq,
   output logic compare2_irq,
   output logic compare3_irq,
   input wire logic capture_input_0,
   input wire logic capture_input_1,
   input wire logic capture_input_2,
   input wire logic capture_input_3,
   output logic capture_event_0,
   output logic capture_event_1,
   output logic capture_event_2,
   output logic capture_event_3
);
   logic [6:0] irq_enable [0:3];
   logic [7:0] reload_high_byte [0:3];
   logic [7:0] capture_ctl_1;
   logic [7:0] capture_ctl_3;
   logic [15:0] reload_q [0:3];
   logic [3:0] compare_irq_q;
   wire logic wr_en;
   wire logic [6:0] wr_index;
   wire logic [7:0] wr_data;
   wire logic wr_lane0;
   wire logic wr_hit;
   wire logic [6:0] rd_index;
   wire logic [7:0] rd_data;
   wire logic rd_hit;
   wire logic [3:0] ier_wr_hit;
   wire logic [3:0] ier_rd_hit;
   wire logic [3:0] reload_wr_hit;
   wire logic [3:0] reload_rd_hit;
   wire logic cap1_wr_hit;
   wire logic cap3_wr_hit;
   wire logic cap1_rd_hit;
   wire logic cap3_rd_hit;
   wire logic [7:0] ier_rd_data;
   wire logic [7:0] low_byte [0:3];
   wire logic [3:0] compare_event;
   wire logic [3:0] compare_enable;
   wire logic [3:0] next_compare_irq;
   wire logic [3:0] capture_in;
   wire logic [1:0] edge_sel [0:3];
   wire logic [3:0] capture_pulse;

   // bus slave front end
   tcc_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_index(wr_index),
      .wr_data(wr_data),
      .wr_lane0(wr_lane0),
      .wr_hit(wr_hit),
      .rd_index(rd_index),
      .rd_data(rd_data),
      .rd_hit(rd_hit)
   );

   // gather per-channel ports into vectors
   assign low_byte[0] = reload_low_byte_0;
   assign low_byte[1] = reload_low_byte_1;
   assign low_byte[2] = reload_low_byte_2;
   assign low_byte[3] = reload_low_byte_3;
   assign compare_event = {compare_channel_3, compare_channel_2,
                           compare_channel_1, compare_channel_0};
   assign capture_in = {capture_input_3, capture_input_2, capture_input_1, capture_input_0};

   // capture decode, only two timers hold a capture register
   assign cap1_wr_hit = (wr_index == tcc_pkg::CAP1_IDX);
   assign cap3_wr_hit = (wr_index == tcc_pkg::CAP3_IDX);
   assign cap1_rd_hit = (rd_index == tcc_pkg::CAP1_IDX);
   assign cap3_rd_hit = (rd_index == tcc_pkg::CAP3_IDX);

   // per-timer decode, storage and reload assembly
   genvar t;
   generate
      for (t = 0; t < tcc_pkg::TIMERS; t++) begin : g_timer
         assign ier_wr_hit[t] = (wr_index == tcc_pkg::IER_IDX[t]);
         assign ier_rd_hit[t] = (rd_index == tcc_pkg::IER_IDX[t]);
         assign reload_wr_hit[t] = (wr_index == tcc_pkg::RELOAD_IDX[t]);
         assign reload_rd_hit[t] = (rd_index == tcc_pkg::RELOAD_IDX[t]);

         // enable and reload high registers; bit 7 of enable not stored
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               irq_enable[t] <= tcc_pkg::REG_RESET[6:0];
               reload_high_byte[t] <= tcc_pkg::REG_RESET;
            end else if (wr_en && wr_lane0) begin
               if (ier_wr_hit[t]) begin
                  irq_enable[t] <= wr_data[6:0];
               end
               if (reload_wr_hit[t]) begin
                  reload_high_byte[t] <= wr_data;
               end
            end
         end

         // reload value register
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               reload_q[t] <= 16'h0000;
            end else begin
               reload_q[t] <= {reload_high_byte[t], low_byte[t]};
            end
         end
      end
   endgenerate

   // capture edge control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_ctl_1 <= tcc_pkg::REG_RESET;
         capture_ctl_3 <= tcc_pkg::REG_RESET;
      end else if (wr_en && wr_lane0) begin
         if (cap1_wr_hit) begin
            capture_ctl_1 <= wr_data;
         end
         if (cap3_wr_hit) begin
            capture_ctl_3 <= wr_data;
         end
      end
   end

   // hit and read data selection, reload high reads as zero
   assign wr_hit = (|ier_wr_hit) || (|reload_wr_hit) || cap1_wr_hit || cap3_wr_hit;
   assign rd_hit = (|ier_rd_hit) || (|reload_rd_hit) || cap1_rd_hit || cap3_rd_hit;
   assign ier_rd_data = ier_rd_hit[0] ? {1'b0, irq_enable[0]} :
                        ier_rd_hit[1] ? {1'b0, irq_enable[1]} :
                        ier_rd_hit[2] ? {1'b0, irq_enable[2]} :
                        ier_rd_hit[3] ? {1'b0, irq_enable[3]} : 8'h00;
   assign rd_data = cap1_rd_hit ? capture_ctl_1 :
                    cap3_rd_hit ? capture_ctl_3 :
                    ier_rd_data;

   // compare requests, only the compare timer's bits act
   assign compare_enable =
      irq_enable[tcc_pkg::CMP_TIMER][tcc_pkg::CMP_EN_MSB:tcc_pkg::CMP_EN_LSB];
   assign next_compare_irq = compare_event & compare_enable & {4{output_compare_mode}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         compare_irq_q <= 4'h0;
      end else begin
         compare_irq_q <= next_compare_irq;
      end
   end

   // capture field to input mapping
   assign edge_sel[0] = capture_ctl_1[tcc_pkg::CAP_A_LSB +: 2];
   assign edge_sel[1] = capture_ctl_1[tcc_pkg::CAP_B_LSB +: 2];
   assign edge_sel[2] = capture_ctl_3[tcc_pkg::CAP_A_LSB +: 2];
   assign edge_sel[3] = capture_ctl_3[tcc_pkg::CAP_B_LSB +: 2];

   genvar c;
   generate
      for (c = 0; c < tcc_pkg::CAP_CH; c++) begin : g_cap
         tcc_edge_detect u_edge (
            .aclk(aclk),
            .aresetn(aresetn),
            .capture_in(capture_in[c]),
            .edge_sel(edge_sel[c]),
            .capture_pulse(capture_pulse[c])
         );
      end
   endgenerate

   // output fan-out, all from flip-flops
   assign reload_value_0 = reload_q[0];
   assign reload_value_1 = reload_q[1];
   assign reload_value_2 = reload_q[2];
   assign reload_value_3 = reload_q[3];
   assign compare0_irq = compare_irq_q[0];
   assign compare1_irq = compare_irq_q[1];
   assign compare2_irq = compare_irq_q[2];
   assign compare3_irq = compare_irq_q[3];
   assign capture_event_0 = capture_pulse[0];
   assign capture_event_1 = capture_pulse[1];
   assign capture_event_2 = capture_pulse[2];
   assign capture_event_3 = capture_pulse[3];

   // compare request checks
   compare_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (compare_channel_3 && output_compare_mode && irq_enable[3][6]) |=> compare3_irq)
      else $error("compare 3 request missing");
   compare0_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (compare_channel_0 && output_compare_mode && irq_enable[3][3]) |=> compare0_irq)
      else $error("compare 0 request missing");
   compare_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !output_compare_mode |=> !compare0_irq && !compare1_irq && !compare2_irq && !compare3_irq)
      else $error("request outside compare mode");
   compare_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !irq_enable[3][5] |=> !compare2_irq)
      else $error("request from cleared enable");
   inert_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
      compare0_irq |-> $past(irq_enable[3][3]))
      else $error("request from inert enable bit");
   inert_bit1_a: assert property (@(posedge aclk) disable iff (!aresetn)
      compare1_irq |-> $past(irq_enable[3][4]))
      else $error("compare 1 request without enable");

   // reload assembly and access checks
   reload_concat_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 reload_value_1 == {$past(reload_high_byte[1]), $past(reload_low_byte_1)})
      else $error("reload value not assembled");
   reload_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 reload_value_3[15:8] == $past(reload_high_byte[3]))
      else $error("reload high byte misplaced");
   reload_wo_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[8:2] == tcc_pkg::RELOAD_IDX[2])
      |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
      else $error("reload high byte readable");
   reload_reset_a: assert property (@(posedge aclk)
      !aresetn |=> reload_high_byte[0] == 8'h00 && reload_high_byte[3] == 8'h00)
      else $error("reload high not cleared");

   // capture mapping and bus response checks
   cap_only_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_en && wr_index == 7'h65) |=> s_axi_bvalid && s_axi_bresp == tcc_pkg::RESP_SLVERR)
      else $error("capture write on timer 0 taken");
   cap_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (capture_ctl_3[3:2] == 2'h0) |=> !capture_event_3)
      else $error("input 3 not on timer 3 field b");
   cap0_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (capture_ctl_1[1:0] == 2'h0) |=> !capture_event_0)
      else $error("input 0 not on timer 1 field a");
   cap1_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (capture_ctl_1[3:2] == 2'h0) |=> !capture_event_1)
      else $error("input 1 not on timer 1 field b");
   unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && !rd_hit) |=> s_axi_rresp == tcc_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");
   write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> ##1 s_axi_bvalid)
      else $error("write response late");
endmodule // tcc_top
`default_nettype wire

// [tcc_axil_master.sv]
// axi4-lite host model standing in for the processor on the register bus
`default_nettype none
module tcc_axil_master (
   input wire logic aclk,
   output logic [8:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [8:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus from time zero
   initial begin
      s_axi_awaddr = 9'h000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 9'h000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end
   // one write, called just after a rising edge; payload inverted once taken
   task automatic write_reg(input logic [6:0] idx, input logic [7:0] din,
                            input logic [3:0] strb, output logic [1:0] resp);
      logic [7:0] d;
      logic aw_done;
      logic w_done;
      d = din;
      for (int i = 0; i < tcc_pkg::TIMERS; i++)
         if (idx == tcc_pkg::IER_IDX[i]) d[7] = 1'b0;
      if (idx == tcc_pkg::CAP1_IDX || idx == tcc_pkg::CAP3_IDX) d[7:4] = 4'h0;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= strb;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~s_axi_awaddr;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // one read, called just after a rising edge
   task automatic read_reg(input logic [6:0] idx, output logic [31:0] data,
                           output logic [1:0] resp);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~s_axi_araddr;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule // tcc_axil_master
`default_nettype wire

// [tcc_top_tb_top.sv]
// self-checking bench for the timer capture/compare control block
`default_nettype none
module tcc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   wire [8:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] low [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   wire [15:0] rv [4];
   logic mode = 1'b0;
   logic [3:0] cmp_ev = 4'h0;
   logic [3:0] cap_pin = 4'h0;
   wire [3:0] irq, cev;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] rng = 32'h00000055;
   tcc_top u_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready,
      .reload_low_byte_0(low[0]), .reload_low_byte_1(low[1]), .reload_low_byte_2(low[2]),
      .reload_low_byte_3(low[3]), .reload_value_0(rv[0]), .reload_value_1(rv[1]),
      .reload_value_2(rv[2]), .reload_value_3(rv[3]), .output_compare_mode(mode),
      .compare_channel_0(cmp_ev[0]), .compare_channel_1(cmp_ev[1]),
      .compare_channel_2(cmp_ev[2]), .compare_channel_3(cmp_ev[3]),
      .compare0_irq(irq[0]), .compare1_irq(irq[1]), .compare2_irq(irq[2]), .compare3_irq(irq[3]),
      .capture_input_0(cap_pin[0]), .capture_input_1(cap_pin[1]), .capture_input_2(cap_pin[2]),
      .capture_input_3(cap_pin[3]), .capture_event_0(cev[0]), .capture_event_1(cev[1]),
      .capture_event_2(cev[2]), .capture_event_3(cev[3])
   );
   tcc_axil_master u_host (
      .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   // 125 MHz clock
   always #4 aclk = ~aclk;
   // xorshift source of stimulus
   function automatic logic [31:0] rand32();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      @(posedge aclk);
      u_host.write_reg(idx, d, s, r);
   endtask
   task automatic rd(input logic [6:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      u_host.read_reg(idx, d, r);
   endtask
   task automatic stop_test();
      $display("counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // hang guard
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         $display("FAIL timeout expected done seen hang");
         stop_test();
      end
   end
   // main sequence
   initial begin
      logic [31:0] d;
      logic [31:0] x;
      logic [1:0] r;
      logic [7:0] hi;
      logic [7:0] en;
      logic [7:0] cv;
      logic [1:0] cd;
      logic [15:0] exp_rv [4];
      logic [6:0] bad [4];
      bad = '{7'h00, 7'h65, 7'h74, 7'h7F};
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int t = 0; t < 4; t++) begin
         rd(tcc_pkg::IER_IDX[t], d, r);
         check("ier reset", d, 32'h00000000);
         check("reload reset", 32'(rv[t]), 32'h00000000);
      end
      rd(tcc_pkg::CAP1_IDX, d, r);
      check("cap1 reset", d, 32'h00000000);
      rd(tcc_pkg::CAP3_IDX, d, r);
      check("cap3 reset", d, 32'h00000000);
      $display("test reset done");
      for (int t = 0; t < 4; t++) begin
         x = rand32();
         hi = (t == 0) ? 8'h00 : (t == 3) ? 8'hFF : x[7:0];
         low[t] <= x[15:8];
         exp_rv[t] = {hi, x[15:8]};
         wr(tcc_pkg::RELOAD_IDX[t], hi, 4'hF, r);
         check("reload bresp", 32'(r), 32'(tcc_pkg::RESP_OKAY));
         repeat (2) @(negedge aclk);
         check("reload value", 32'(rv[t]), 32'(exp_rv[t]));
         rd(tcc_pkg::RELOAD_IDX[t], d, r);
         check("reload read data", d, 32'h00000000);
         check("reload read resp", 32'(r), 32'(tcc_pkg::RESP_OKAY));
      end
      wr(tcc_pkg::RELOAD_IDX[2], ~exp_rv[2][15:8], 4'h0, r);
      check("no strobe bresp", 32'(r), 32'(tcc_pkg::RESP_OKAY));
      repeat (2) @(negedge aclk);
      check("reload no strobe", 32'(rv[2]), 32'(exp_rv[2]));
      $display("test reload done");
      foreach (bad[i]) begin
         wr(bad[i], 8'hA5, 4'hF, r);
         check("unmapped bresp", 32'(r), 32'(tcc_pkg::RESP_SLVERR));
         rd(bad[i], d, r);
         check("unmapped rresp", 32'(r), 32'(tcc_pkg::RESP_SLVERR));
         check("unmapped rdata", d, 32'h00000000);
      end
      $display("test unmapped done");
      for (int ch = 0; ch < 4; ch++) begin
         for (int code = 0; code < 4; code++) begin
            cd = code[1:0];
            cv = 8'(cd) << ((ch % 2) * 2);
            wr((ch < 2) ? tcc_pkg::CAP1_IDX : tcc_pkg::CAP3_IDX, cv | 8'hF0, 4'hF, r);
            rd((ch < 2) ? tcc_pkg::CAP1_IDX : tcc_pkg::CAP3_IDX, d, r);
            check("capture readback", d, 32'(cv));
            @(posedge aclk);
            cap_pin[ch] <= 1'b1;
            repeat (2) @(negedge aclk);
            check("capture rise", 32'(cev), 32'(4'(cd[1]) << ch));
            @(negedge aclk);
            check("capture width", 32'(cev), 32'h00000000);
            @(posedge aclk);
            cap_pin[ch] <= 1'b0;
            repeat (2) @(negedge aclk);
            check("capture fall", 32'(cev), 32'(4'(cd[0]) << ch));
         end
      end
      $display("test capture done");
      for (int t = 0; t < 3; t++)
         wr(tcc_pkg::IER_IDX[t], 8'hFF, 4'hF, r);
      en = 8'h00;
      for (int n = 0; n < 32; n++) begin
         x = rand32();
         if (n % 8 == 0) begin
            en = (n == 0) ? 8'h87 : x[15:8];
            wr(tcc_pkg::IER_IDX[3], en, 4'hF, r);
            rd(tcc_pkg::IER_IDX[3], d, r);
            check("ier readback", d, 32'(en & 8'h7F));
         end
         @(posedge aclk);
         cmp_ev <= (n < 2) ? 4'hF : x[3:0];
         mode <= (n < 2) ? 1'b1 : x[4];
         @(posedge aclk);
         @(negedge aclk);
         check("compare irq", 32'(irq), 32'(cmp_ev & en[6:3] & {4{mode}}));
      end
      $display("test compare done");
      stop_test();
   end
endmodule // tcc_top_tb_top
`default_nettype wire
